// *** rtl/ebt_timeout.sv ***
// module: bus time-out counter with gated error output and carry pulse
`timescale 1ns/1ps
module ebt_timeout (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic bus_cycle_sync_n,
  input wire logic timeout_gate_n,
  output logic bus_timeout_error_n,
  output logic carry_pulse_n
);
  ebt_tick_if tk ();

  ebt_prescaler u_pre (
    .ref_clk(ref_clk),
    .rst(rst),
    .tk(tk)
  );

  ////////////////////////////////////////////////////////////////////////
  logic pending;
  logic gate_open;
  logic tick;
  logic at_carry;
  logic at_arm;
  logic [ebt_pkg::CNT_W-1:0] cnt_ff;
  logic [ebt_pkg::CNT_W-1:0] nxt_cnt;
  logic [ebt_pkg::CNT_W-1:0] arm_ff;
  logic [ebt_pkg::CNT_W-1:0] nxt_arm;
  logic armed_ff;
  logic nxt_armed;
  logic err_ff;
  logic nxt_err;
  logic carry_ff;
  logic nxt_carry;

  assign pending = !bus_cycle_sync_n;
  assign tk.run = pending;
  assign tick = tk.tick;
  assign gate_open = !timeout_gate_n;
  assign at_carry = (cnt_ff == ebt_pkg::CARRY_AT);
  assign at_arm = (cnt_ff == arm_ff);

  ////////////////////////////////////////////////////////////////////////
  // six-stage microcycle counter
  always_comb begin
    nxt_cnt = cnt_ff;
    if (!pending) begin
      nxt_cnt = ebt_pkg::CNT_RESET;
    end else if (tick) begin
      // keeps counting whether or not the error is gated off
      nxt_cnt = cnt_ff + 6'h01;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= ebt_pkg::CNT_RESET;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // carry pulse for the outside extension stage
  always_comb begin
    nxt_carry = carry_ff;
    if (!pending) begin
      nxt_carry = 1'b0;
    end else if (tick) begin
      // set on the wrap and held to the next tick, so exactly one microcycle wide
      nxt_carry = at_carry;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      carry_ff <= 1'b0;
    end else begin
      carry_ff <= nxt_carry;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // count-down start point
  always_comb begin
    nxt_arm = arm_ff;
    nxt_armed = armed_ff;
    if (!pending || !gate_open) begin
      // a closed gate forgets the count-down, so a reopened gate gets a full one
      nxt_armed = 1'b0;
    end else if (tick && !armed_ff) begin
      // count-down starts from the tick at which the gate is first seen open
      nxt_armed = 1'b1;
      nxt_arm = cnt_ff + 6'(ebt_pkg::TIMEOUT_COUNTS - 1);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      arm_ff <= ebt_pkg::CNT_RESET;
      armed_ff <= 1'b0;
    end else begin
      arm_ff <= nxt_arm;
      armed_ff <= nxt_armed;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // time-out error toward the cpu control logic
  always_comb begin
    nxt_err = err_ff;
    if (!pending || !gate_open) begin
      nxt_err = 1'b0;
    end else if (tick && armed_ff && at_arm) begin
      nxt_err = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      err_ff <= 1'b0;
    end else begin
      err_ff <= nxt_err;
    end
  end

  assign bus_timeout_error_n = !err_ff;
  assign carry_pulse_n = !carry_ff;
endmodule

// *** rtl/ebt_pkg.sv ***
// package: constants for the extended bus time-out logic
package ebt_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  // microcycle of the processor, in ns
  localparam int unsigned MICROCYCLE_NS = 380;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  // ref_clk cycles per microcycle; 380 ns is not a whole number of 50 ns periods, so round down
  localparam int unsigned MICROCYCLE_CYC_RAW = MICROCYCLE_NS / CLK_PERIOD_NS;
  localparam int unsigned MICROCYCLE_CYC = (MICROCYCLE_CYC_RAW < 1) ? 1 : MICROCYCLE_CYC_RAW;
  localparam int unsigned DIV_W = 4;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MICROCYCLE_CYC - 1);
  localparam logic [DIV_W-1:0] DIV_RESET = 4'h0;
  // six-stage counter
  localparam int unsigned CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;
  // normal time-out: 32 counts (12.16 us)
  localparam int unsigned TIMEOUT_COUNTS = 32;
  localparam int unsigned TIMEOUT_NS = 12_160;
  // carry: once every 64 counts (24.32 us)
  localparam int unsigned CARRY_COUNTS = 64;
  localparam int unsigned CARRY_NS = 24_320;
  localparam logic [CNT_W-1:0] CARRY_AT = 6'h3f;
endpackage

// *** rtl/ebt_if.sv ***
// interface: microcycle tick between the prescaler and the time-out counter
`timescale 1ns/1ps
interface ebt_tick_if;
  logic tick;
  logic run;
  modport src (output tick, input run);
  modport dst (input tick, output run);
endinterface

// *** rtl/ebt_prescaler.sv ***
// module: divides ref_clk down to the phase-three microcycle tick
`timescale 1ns/1ps
module ebt_prescaler (
  input wire logic ref_clk,
  input wire logic rst,
  ebt_tick_if.src tk
);
  logic [ebt_pkg::DIV_W-1:0] div_ff;
  logic [ebt_pkg::DIV_W-1:0] nxt_div;
  logic tick_ff;
  logic nxt_tick;

  always_comb begin
    nxt_div = div_ff;
    nxt_tick = 1'b0;
    if (!tk.run) begin
      // restart phase with every bus cycle so counts line up with the cycle start
      nxt_div = ebt_pkg::DIV_RESET;
    end else if (div_ff == ebt_pkg::DIV_LAST) begin
      nxt_div = ebt_pkg::DIV_RESET;
      nxt_tick = 1'b1;
    end else begin
      nxt_div = div_ff + 4'h1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_ff <= ebt_pkg::DIV_RESET;
      tick_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      tick_ff <= nxt_tick;
    end
  end

  assign tk.tick = tick_ff;
endmodule

// *** tb/ebt_timeout_properties.sv ***
// checker: port properties of the bus time-out block
`timescale 1ns/1ps
module ebt_timeout_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic bus_cycle_sync_n,
  input wire logic timeout_gate_n,
  input wire logic bus_timeout_error_n,
  input wire logic carry_pulse_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  gate_block_a: assert property (timeout_gate_n |=> bus_timeout_error_n)
    else $error("error while gated");
  sync_clear_a: assert property (bus_cycle_sync_n |=> bus_timeout_error_n)
    else $error("error outside cycle");
  err_hold_a: assert property (!bus_timeout_error_n && !bus_cycle_sync_n && !timeout_gate_n |=> !bus_timeout_error_n)
    else $error("error dropped");
  min_delay_a: assert property ($fell(bus_timeout_error_n) |-> !$past(bus_cycle_sync_n, 224))
    else $error("error too early");
  gate_run_a: assert property ($fell(bus_timeout_error_n) |-> !$past(timeout_gate_n, 217))
    else $error("error too soon after gate");
  carry_wide_a: assert property ($fell(carry_pulse_n) |-> (!carry_pulse_n)[*7] ##1 carry_pulse_n)
    else $error("carry width wrong");
  carry_gap_a: assert property ($fell(carry_pulse_n) |-> !$past(bus_cycle_sync_n, 448))
    else $error("carry too early");
  cover property ($fell(bus_timeout_error_n));
  cover property ($fell(carry_pulse_n));
  cover property ($fell(timeout_gate_n));
endmodule
bind ebt_timeout ebt_timeout_chk u_chk (.ref_clk(ref_clk), .rst(rst), .bus_cycle_sync_n(bus_cycle_sync_n),
  .timeout_gate_n(timeout_gate_n), .bus_timeout_error_n(bus_timeout_error_n), .carry_pulse_n(carry_pulse_n));

// *** tb/ebt_ext_stage.sv ***
// partner: external extension counter driving the gate input
`timescale 1ns/1ps
module ebt_ext_stage #(
  parameter int N = 1
) (
  input wire logic rst,
  input wire logic bus_cycle_sync_n,
  input wire logic carry_pulse_n,
  output logic timeout_gate_n
);
  int cnt = 0;
  // clocked by the carry itself, as the outside stage is; sync clears it
  always @(negedge carry_pulse_n or posedge bus_cycle_sync_n or posedge rst) begin
    if (rst || bus_cycle_sync_n) cnt <= 0;
    else if (cnt < N) cnt <= cnt + 1;
  end
  assign timeout_gate_n = (cnt < N);
endmodule

// *** tb/tb_top.sv ***
// testbench: time-out delays with and without extension
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 0, rst = 1, sync_n = 1, gate_drv = 0, use_ext = 0;
  logic err_n, carry_n, ext_gate_n;
  int num_errors = 0, n_tests = 0, k, n_carry = 0, c0;
  // expected edges: a microcycle per count, plus one edge for the registered error
  typedef struct {logic ext; int n; int exp_k;} ebt_row_t;
  ebt_row_t rows [2] = '{'{1'b0, 0, ebt_pkg::MICROCYCLE_CYC * ebt_pkg::TIMEOUT_COUNTS + 1},
    '{1'b1, 2, ebt_pkg::MICROCYCLE_CYC * (ebt_pkg::TIMEOUT_COUNTS + 2 * ebt_pkg::CARRY_COUNTS) + 1}};
  initial forever #25 ref_clk = ~ref_clk;
  always @(negedge carry_n) n_carry++;
  ebt_timeout u_dut (.ref_clk(ref_clk), .rst(rst), .bus_cycle_sync_n(sync_n),
    .timeout_gate_n(use_ext ? ext_gate_n : gate_drv), .bus_timeout_error_n(err_n), .carry_pulse_n(carry_n));
  ebt_ext_stage #(.N(2)) u_ext (.rst(rst), .bus_cycle_sync_n(sync_n), .carry_pulse_n(carry_n),
    .timeout_gate_n(ext_gate_n));
  task chk(logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("tests=%0d errors=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // counted on falling edges so the registered error has settled
  task run_to_err(int lim);
    k = 0;
    while (err_n !== 1'b0 && k < lim) begin
      @(negedge ref_clk);
      k++;
    end
  endtask
  initial begin
    repeat (10) @(negedge ref_clk);
    rst = 0;
    foreach (rows[i]) begin
      use_ext = rows[i].ext;
      sync_n = 0;
      run_to_err(2000);
      chk(k, rows[i].exp_k);
      sync_n = 1;
      repeat (2) @(negedge ref_clk);
      chk(err_n, 1);
      $display("row %0d done", i);
    end
    use_ext = 0;
    gate_drv = 1;
    sync_n = 0;
    c0 = n_carry;
    run_to_err(500);
    chk(err_n, 1);
    chk(n_carry - c0, 1);
    gate_drv = 0;
    run_to_err(300);
    chk(k >= ebt_pkg::MICROCYCLE_CYC * 31 + 1 && k <= ebt_pkg::MICROCYCLE_CYC * 32, 1);
    gate_drv = 1;
    repeat (2) @(negedge ref_clk);
    chk(err_n, 1);
    $display("gated case done");
    close_out;
  end
  initial begin
    #400_000;
    num_errors++;
    close_out;
  end
endmodule
